// File: rtl/dmar_top.v
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/100ps
`include "dmar_defs.vh"
module dmar_top (
   ref_clk,
   rstn,
   reg_addr,
   reg_wdata,
   reg_wr,
   reg_rd,
   reg_rdata,
   ext_request_n,
   ext_acknowledge,
   periph_req0,
   periph_req1,
   uart_tx_ready_req_n,
   uart_rx_ready_req_n,
   endpoint2_dma_req_n,
   endpoint3_dma_req_n,
   bus_addr,
   bus_rd,
   bus_wr,
   bus_done,
   bus_rdata,
   external_data_bus_out,
   external_data_bus_oe,
   channel_irq,
   config_error
);
   input wire ref_clk;
   input wire rstn;
   input wire [3:0] reg_addr;
   input wire [7:0] reg_wdata;
   input wire reg_wr;
   input wire reg_rd;
   output reg [7:0] reg_rdata;
   input wire [1:0] ext_request_n;
   output reg [1:0] ext_acknowledge;
   input wire [23:0] periph_req0;
   input wire [23:0] periph_req1;
   input wire uart_tx_ready_req_n;
   input wire uart_rx_ready_req_n;
   input wire endpoint2_dma_req_n;
   input wire endpoint3_dma_req_n;
   output reg [7:0] bus_addr;
   output reg bus_rd;
   output reg bus_wr;
   input wire bus_done;
   input wire [15:0] bus_rdata;
   output reg [15:0] external_data_bus_out;
   output reg external_data_bus_oe;
   output reg [1:0] channel_irq;
   output reg [1:0] config_error;

   ////////////////////////////////////////////////////////////////////////////
   // registers
   reg [7:0] mode_q [0:1];
   reg [4:0] src_q [0:1];
   reg [7:0] cnt_q [0:1];
   reg [5:0] devs_q [0:1];
   reg [7:0] cmd_q;
   reg [1:0] end_q;
   reg [1:0] sw_pend_q;
   reg [2:0] st_q;
   reg act_q;
   // request status samples: peripheral pin bits one cycle, external request bits three cycles behind the pins
   reg [5:0] reqst_q;
   wire [1:0] ext_pulse;
   wire [1:0] ext_level;
   wire [1:0] trig;
   wire [1:0] from_ext;
   wire [1:0] ready;
   wire [1:0] legal;
   wire [23:0] preq [0:1];
   assign preq[0] = periph_req0;
   assign preq[1] = periph_req1;

   ////////////////////////////////////////////////////////////////////////////
   // per-channel request path
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : ch
         wire [2:0] sdev;
         wire [2:0] ddev;
         wire single_ok;
         wire dual_ok;
         dmar_req_sense u_sense (
            .ref_clk(ref_clk),
            .rstn(rstn),
            .ext_request_n(ext_request_n[g]),
            .request_sense_select(mode_q[g][`DMAR_MODE_SENSE]),
            .ext_req_pulse(ext_pulse[g]),
            .ext_req_level(ext_level[g])
         );
         dmar_src_mux u_mux (
            .request_source_select(src_q[g]),
            .ext_req(ext_pulse[g]),
            .sw_req(sw_pend_q[g]),
            .periph_req(preq[g]),
            .trig(trig[g]),
            .from_ext(from_ext[g])
         );
         assign sdev = devs_q[g][2:0];
         assign ddev = devs_q[g][5:3];
         // ack device paired with external memory only
         assign single_ok = ((sdev == `DMAR_DEV_XACK) && (ddev == `DMAR_DEV_XMEM || ddev == `DMAR_DEV_XMAP)) ||
                            ((ddev == `DMAR_DEV_XACK) && (sdev == `DMAR_DEV_XMEM || sdev == `DMAR_DEV_XMAP));
         // any pair of codes up to ack, but not ack to ack
         assign dual_ok = !((sdev == `DMAR_DEV_XACK) && (ddev == `DMAR_DEV_XACK)) &&
                          (sdev <= `DMAR_DEV_XACK) && (ddev <= `DMAR_DEV_XACK);
         assign legal[g] = mode_q[g][`DMAR_MODE_ADM] ? dual_ok : single_ok;
         assign ready[g] = cmd_q[`DMAR_CMD_MASTER] & mode_q[g][`DMAR_MODE_EN] & legal[g] & (cnt_q[g] != 8'h00);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // channel selection: channel 0 first
   wire idle = (st_q == `DMAR_ST_IDLE);
   wire go0 = idle & ready[0] & trig[0];
   wire go1 = idle & ~go0 & ready[1] & trig[1];
   wire go = go0 | go1;
   wire gch = go1;
   // final item of the active channel
   wire last = (cnt_q[act_q] == 8'h01);

   ////////////////////////////////////////////////////////////////////////////
   // register writes and channel bookkeeping
   integer i;
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         for (i = 0; i < 2; i = i + 1) begin
            mode_q[i] <= `DMAR_RST_8;
            src_q[i] <= 5'h00;
            cnt_q[i] <= `DMAR_RST_8;
            devs_q[i] <= 6'h00;
         end
         cmd_q <= `DMAR_RST_8;
         end_q <= 2'b00;
         sw_pend_q <= 2'b00;
         channel_irq <= 2'b00;
      end else begin
         // accepted software start no longer pending
         if (go && src_q[gch] == `DMAR_SRC_SW)
            sw_pend_q[gch] <= 1'b0;
         // a start written in the same cycle wins over acceptance
         for (i = 0; i < 2; i = i + 1) begin
            if (reg_wr && reg_addr == (`DMAR_OFS_MODE0 + i[3:0])) begin
               mode_q[i] <= {reg_wdata[7:2], 1'b0, reg_wdata[0]};
               if (reg_wdata[`DMAR_MODE_SWS])
                  sw_pend_q[i] <= 1'b1;
            end
            if (reg_wr && reg_addr == (`DMAR_OFS_SRC0 + i[3:0]))
               src_q[i] <= reg_wdata[4:0];
            if (reg_wr && reg_addr == (`DMAR_OFS_CNT0 + i[3:0]))
               cnt_q[i] <= reg_wdata;
            if (reg_wr && reg_addr == (`DMAR_OFS_DEVS0 + i[3:0]))
               devs_q[i] <= reg_wdata[5:0];
            // clear by writing 1; new end event wins
            if (reg_wr && reg_addr == `DMAR_OFS_END && reg_wdata[i])
               end_q[i] <= 1'b0;
         end
         if (reg_wr && reg_addr == `DMAR_OFS_CMD)
            cmd_q <= {3'b000, reg_wdata[4:0]};
         // interrupt is a one-cycle pulse
         channel_irq <= 2'b00;
         if (st_q == `DMAR_ST_DONE) begin
            cnt_q[act_q] <= cnt_q[act_q] - 8'h01;
            if (last) begin
               end_q[act_q] <= 1'b1;
               mode_q[act_q][`DMAR_MODE_EN] <= 1'b0;
               channel_irq[act_q] <= act_q ? cmd_q[`DMAR_CMD_IE1] : cmd_q[`DMAR_CMD_IE0];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus cycle engine
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_q <= `DMAR_ST_IDLE;
         act_q <= 1'b0;
         bus_addr <= 8'h00;
         bus_rd <= 1'b0;
         bus_wr <= 1'b0;
         ext_acknowledge <= 2'b00;
         external_data_bus_out <= 16'h0000;
         external_data_bus_oe <= 1'b0;
      end else begin
         case (st_q)
            // wait for an accepted request
            `DMAR_ST_IDLE: begin
               if (go) begin
                  act_q <= gch;
                  bus_addr <= {gch, 7'h00};
                  if (mode_q[gch][`DMAR_MODE_ADM]) begin
                     st_q <= `DMAR_ST_RD;
                     bus_rd <= 1'b1;
                  end else begin
                     st_q <= `DMAR_ST_SINGLE;
                     bus_rd <= (devs_q[gch][2:0] != `DMAR_DEV_XACK);
                     bus_wr <= (devs_q[gch][2:0] == `DMAR_DEV_XACK);
                     external_data_bus_oe <= 1'b0;
                     // the ack device is strobed for the whole access
                     ext_acknowledge[gch] <= 1'b1;
                  end
               end
            end
            // single: one access, own data pins released
            `DMAR_ST_SINGLE: begin
               if (bus_done) begin
                  bus_rd <= 1'b0;
                  bus_wr <= 1'b0;
                  ext_acknowledge <= 2'b00;
                  st_q <= `DMAR_ST_DONE;
               end
            end
            // dual read: wait for the source
            `DMAR_ST_RD: begin
               if (bus_done) begin
                  // read data goes straight to the write cycle
                  bus_rd <= 1'b0;
                  bus_wr <= 1'b1;
                  bus_addr <= {act_q, 7'h01};
                  external_data_bus_out <= bus_rdata;
                  external_data_bus_oe <= 1'b1;
                  if (from_ext[act_q])
                     ext_acknowledge[act_q] <= 1'b1;
                  st_q <= `DMAR_ST_WR;
               end
            end
            // dual write: drive the captured item
            `DMAR_ST_WR: begin
               if (bus_done) begin
                  bus_wr <= 1'b0;
                  external_data_bus_oe <= 1'b0;
                  ext_acknowledge <= 2'b00;
                  st_q <= `DMAR_ST_DONE;
               end
            end
            // one cycle for count and end bookkeeping
            `DMAR_ST_DONE: st_q <= `DMAR_ST_IDLE;
            default: st_q <= `DMAR_ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // request status and readback
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         reqst_q <= 6'h00;
         config_error <= 2'b00;
         reg_rdata <= 8'h00;
      end else begin
         reqst_q <= {ext_level[1], ext_level[0], ~endpoint3_dma_req_n, ~endpoint2_dma_req_n,
                     ~uart_rx_ready_req_n, ~uart_tx_ready_req_n};
         config_error <= {mode_q[1][`DMAR_MODE_EN] & ~legal[1], mode_q[0][`DMAR_MODE_EN] & ~legal[0]};
         // read data stands one cycle, else zero
         reg_rdata <= 8'h00;
         if (reg_rd) begin
            case (reg_addr)
               `DMAR_OFS_MODE0: reg_rdata <= mode_q[0];
               `DMAR_OFS_MODE1: reg_rdata <= mode_q[1];
               `DMAR_OFS_SRC0: reg_rdata <= {3'b000, src_q[0]};
               `DMAR_OFS_SRC1: reg_rdata <= {3'b000, src_q[1]};
               `DMAR_OFS_CNT0: reg_rdata <= cnt_q[0];
               `DMAR_OFS_CNT1: reg_rdata <= cnt_q[1];
               `DMAR_OFS_CMD: reg_rdata <= cmd_q;
               `DMAR_OFS_END: reg_rdata <= {4'h0, 2'b00, end_q};
               `DMAR_OFS_REQST: reg_rdata <= {2'b00, reqst_q};
               `DMAR_OFS_DEVS0: reg_rdata <= {2'b00, devs_q[0]};
               `DMAR_OFS_DEVS1: reg_rdata <= {2'b00, devs_q[1]};
               default: reg_rdata <= 8'h00;
            endcase
         end
      end
   end
endmodule // dmar_top

// File: rtl/dmar_defs.vh
`ifndef DMAR_DEFS_VH
`define DMAR_DEFS_VH
// register offsets (byte addresses, 8-bit registers)
`define DMAR_ADDR_W 4
`define DMAR_OFS_MODE0 4'h0
`define DMAR_OFS_MODE1 4'h1
`define DMAR_OFS_SRC0 4'h2
`define DMAR_OFS_SRC1 4'h3
`define DMAR_OFS_CNT0 4'h4
`define DMAR_OFS_CNT1 4'h5
`define DMAR_OFS_CMD 4'h6
`define DMAR_OFS_END 4'h7
`define DMAR_OFS_REQST 4'h8
`define DMAR_OFS_DEVS0 4'h9
`define DMAR_OFS_DEVS1 4'hA
// channel mode register fields
`define DMAR_MODE_EN 0
`define DMAR_MODE_SWS 1
`define DMAR_MODE_SENSE 2
`define DMAR_MODE_ADM 3
// command register fields
`define DMAR_CMD_MASTER 0
`define DMAR_CMD_IE0 3
`define DMAR_CMD_IE1 4
// source selector codes
`define DMAR_SRC_SW 5'h00
`define DMAR_SRC_EXT 5'h07
// device class codes (3 bits: src [2:0], dst [5:3])
`define DMAR_DEV_IMEM 3'h0
`define DMAR_DEV_IPER 3'h1
`define DMAR_DEV_XMEM 3'h2
`define DMAR_DEV_XMAP 3'h3
`define DMAR_DEV_XACK 3'h4
// reset values
`define DMAR_RST_8 8'h00
// bus cycle states
`define DMAR_ST_IDLE 3'h0
`define DMAR_ST_SINGLE 3'h1
`define DMAR_ST_RD 3'h2
`define DMAR_ST_WR 3'h3
`define DMAR_ST_DONE 3'h4
`endif

// File: rtl/dmar_req_sense.v
`timescale 1ns/100ps
`include "dmar_defs.vh"
module dmar_req_sense (
   input wire ref_clk,
   input wire rstn,
   input wire ext_request_n,
   input wire request_sense_select,
   output wire ext_req_pulse,
   output wire ext_req_level
);
   reg s1_q;
   reg s2_q;
   reg s3_q;
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         s3_q <= 1'b1;
      end else begin
         s1_q <= ext_request_n;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   assign ext_req_level = ~s2_q;
   // edge: previous high, current low; level: low
   assign ext_req_pulse = request_sense_select ? (s3_q & ~s2_q) : ~s2_q;
endmodule // dmar_req_sense

// File: rtl/dmar_src_mux.v
`timescale 1ns/100ps
`include "dmar_defs.vh"
module dmar_src_mux (
   input wire [4:0] request_source_select,
   input wire ext_req,
   input wire sw_req,
   input wire [23:0] periph_req,
   output reg trig,
   output reg from_ext
);
   always @* begin
      trig = 1'b0;
      from_ext = 1'b0;
      case (request_source_select)
         `DMAR_SRC_SW: trig = sw_req;
         `DMAR_SRC_EXT: begin
            trig = ext_req;
            from_ext = 1'b1;
         end
         default: begin
            // codes 1..6 and 8..25 map to peripheral lines
            if (request_source_select < `DMAR_SRC_EXT)
               trig = periph_req[request_source_select - 5'h01];
            else if (request_source_select < 5'h1A)
               trig = periph_req[request_source_select - 5'h02];
            else
               trig = 1'b0;
         end
      endcase
   end
endmodule // dmar_src_mux

// File: test/dmar_chk.sv
`timescale 1ns/100ps
module dmar_chk (
   input wire ref_clk,
   input wire rstn,
   input wire [1:0] ext_acknowledge,
   input wire [7:0] bus_addr,
   input wire bus_rd,
   input wire bus_wr,
   input wire bus_done,
   input wire external_data_bus_oe,
   input wire [1:0] channel_irq
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);
   sequence s_rd_end;
      bus_rd && bus_done;
   endsequence
   sequence s_wr_go;
      bus_wr;
   endsequence
   property p_dual_wr; s_rd_end ##1 s_wr_go |-> external_data_bus_oe && bus_addr[6:0] == 7'h01; endproperty
   a_dual_wr: assert property (p_dual_wr) else $error("write after read not driven");
   property p_oe_wr; external_data_bus_oe |-> bus_wr && bus_addr[6:0] == 7'h01; endproperty
   a_oe_wr: assert property (p_oe_wr) else $error("data bus driven outside write");
   property p_excl; !(bus_rd && bus_wr); endproperty
   a_excl: assert property (p_excl) else $error("read and write together");
   property p_rd_hold; bus_rd && !bus_done |=> bus_rd && $stable(bus_addr); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read not held");
   property p_wr_rel; bus_wr && bus_done |=> !bus_wr && !external_data_bus_oe; endproperty
   a_wr_rel: assert property (p_wr_rel) else $error("write not released");
   property p_rd_addr; bus_rd |-> bus_addr[6:0] == 7'h00; endproperty
   a_rd_addr: assert property (p_rd_addr) else $error("read address wrong");
   property p_ack_ch;
      ext_acknowledge != 2'b00 |-> (bus_rd || bus_wr) && ext_acknowledge == (bus_addr[7] ? 2'b10 : 2'b01);
   endproperty
   a_ack_ch: assert property (p_ack_ch) else $error("acknowledge on wrong channel");
   property p_ack_held; ext_acknowledge != 2'b00 && !bus_done |=> ext_acknowledge == $past(ext_acknowledge); endproperty
   a_ack_held: assert property (p_ack_held) else $error("acknowledge dropped in access");
   property p_irq_pulse; channel_irq != 2'b00 |=> channel_irq == 2'b00; endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt longer than one cycle");
endmodule // dmar_chk
bind dmar_top dmar_chk u_dmar_chk (.ref_clk(ref_clk), .rstn(rstn), .ext_acknowledge(ext_acknowledge),
   .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_done(bus_done),
   .external_data_bus_oe(external_data_bus_oe), .channel_irq(channel_irq));

// File: test/dmar_bus_model.sv
`timescale 1ns/100ps
module dmar_bus_model (
   input wire ref_clk,
   input wire rstn,
   input wire bus_rd,
   input wire bus_wr,
   input wire [3:0] lat,
   output reg bus_done,
   output reg [15:0] bus_rdata
);
   reg [3:0] wait_q;
   // memory answers after lat extra cycles, data churns otherwise
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         bus_done <= 1'b0;
         bus_rdata <= 16'h0000;
         wait_q <= 4'h0;
      end else begin
         bus_done <= 1'b0;
         bus_rdata <= ~bus_rdata;
         if ((bus_rd || bus_wr) && !bus_done) begin
            wait_q <= wait_q + 4'h1;
            if (wait_q == lat) begin
               bus_done <= 1'b1;
               bus_rdata <= 16'hA5C3;
               wait_q <= 4'h0;
            end
         end
      end
   end
endmodule // dmar_bus_model

// File: test/dmar_top_test.sv
`timescale 1ns/100ps
module dmar_top_test;
   reg ref_clk = 1'b0;
   reg rstn = 1'b0;
   reg [3:0] reg_addr = 4'h0;
   reg [7:0] reg_wdata = 8'h00;
   reg reg_wr = 1'b0;
   reg reg_rd = 1'b0;
   reg [1:0] ext_request_n = 2'b11;
   reg [23:0] periph_req1 = 24'h000000;
   reg [3:0] st_n = 4'hF;
   reg [3:0] lat = 4'h0;
   reg [39:0] codes = {8'h1A, 8'h19, 8'h08, 8'h06, 8'h01};
   reg [7:0] c;
   wire [7:0] reg_rdata, bus_addr;
   wire [1:0] ext_acknowledge, channel_irq, config_error;
   wire bus_rd, bus_wr, bus_done, external_data_bus_oe;
   wire [15:0] bus_rdata, external_data_bus_out;
   integer n_mismatch = 0;
   integer num_checks = 0;
   integer n_rd = 0, n_wr = 0, n_oe = 0, n_ack = 0, n_irq = 0, i;
   dmar_top u_dmar_top (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_request_n(ext_request_n),
      .ext_acknowledge(ext_acknowledge), .periph_req0(24'h000000), .periph_req1(periph_req1),
      .uart_tx_ready_req_n(st_n[0]), .uart_rx_ready_req_n(st_n[1]), .endpoint2_dma_req_n(st_n[2]),
      .endpoint3_dma_req_n(st_n[3]), .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr),
      .bus_done(bus_done), .bus_rdata(bus_rdata), .external_data_bus_out(external_data_bus_out),
      .external_data_bus_oe(external_data_bus_oe), .channel_irq(channel_irq), .config_error(config_error));
   dmar_bus_model u_dmar_bus_model (.ref_clk(ref_clk), .rstn(rstn), .bus_rd(bus_rd), .bus_wr(bus_wr),
      .lat(lat), .bus_done(bus_done), .bus_rdata(bus_rdata));
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      if (bus_rd === 1'b1 && bus_done === 1'b1) n_rd = n_rd + 1;
      if (bus_wr === 1'b1 && bus_done === 1'b1) n_wr = n_wr + 1;
      if (bus_wr === 1'b1 && bus_done === 1'b1 && external_data_bus_oe === 1'b1 &&
          external_data_bus_out === 16'hA5C3) n_oe = n_oe + 1;
      if (|ext_acknowledge === 1'b1 && bus_done === 1'b1) n_ack = n_ack + 1;
      if (|channel_irq === 1'b1) n_irq = n_irq + 1;
   end
   //////////////////////////////////////////////////////////////////
   task give_verdict;
      begin
         if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
         else $display("DONE - FAIL");
         $finish;
      end
   endtask
   task chk(input [15:0] seen, input [15:0] exp);
      begin
         num_checks = num_checks + 1;
         if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task wr(input [3:0] a, input [7:0] d);
      begin
         @(posedge ref_clk);
         reg_addr <= a;
         reg_wdata <= d;
         reg_wr <= 1'b1;
         @(posedge ref_clk);
         reg_wr <= 1'b0;
      end
   endtask
   task rd(input [3:0] a, input [7:0] exp);
      begin
         @(posedge ref_clk);
         reg_addr <= a;
         reg_rd <= 1'b1;
         @(posedge ref_clk);
         reg_rd <= 1'b0;
         #1 chk({8'h00, reg_rdata}, {8'h00, exp});
      end
   endtask
   task quiet;
      integer k, j;
      begin
         k = 0;
         for (j = 0; j < 400 && k < 10; j = j + 1) begin
            @(posedge ref_clk);
            k = (bus_rd === 1'b0 && bus_wr === 1'b0) ? k + 1 : 0;
         end
         chk(k[15:0], 16'h000A);
      end
   endtask
   task pulse(input integer len);
      begin
         @(posedge ref_clk);
         ext_request_n[1] <= 1'b0;
         repeat (len) @(posedge ref_clk);
         ext_request_n[1] <= 1'b1;
         repeat (len) @(posedge ref_clk);
      end
   endtask
   task cfg(input [7:0] devs, input [7:0] mode, input [1:0] exp);
      begin
         wr(4'hA, devs);
         wr(4'h1, mode);
         repeat (3) @(posedge ref_clk);
         #1 chk({14'h0000, config_error}, {14'h0000, exp});
      end
   endtask
   task clr;
      begin
         n_rd = 0;
         n_wr = 0;
         n_oe = 0;
         n_ack = 0;
         n_irq = 0;
      end
   endtask
   //////////////////////////////////////////////////////////////////
   initial begin
      #2000000 n_mismatch = n_mismatch + 1;
      give_verdict;
   end
   initial begin
      repeat (6) @(posedge ref_clk);
      rstn <= 1'b1;
      rd(4'h0, 8'h00);
      rd(4'h5, 8'h00);
      rd(4'h7, 8'h00);
      rd(4'h8, 8'h00);
      wr(4'hF, 8'hFF);
      rd(4'hF, 8'h00);
      // software start, dual, slow memory
      wr(4'h9, 8'h02);
      wr(4'h2, 8'h00);
      wr(4'h4, 8'h02);
      wr(4'h6, 8'h09);
      lat <= 4'h3;
      wr(4'h0, 8'h0B);
      quiet;
      chk(n_rd[15:0], 16'h0001);
      chk(n_oe[15:0], 16'h0001);
      rd(4'h4, 8'h01);
      rd(4'h0, 8'h09);
      wr(4'h0, 8'h0B);
      quiet;
      chk(n_wr[15:0], 16'h0002);
      chk(n_irq[15:0], 16'h0001);
      rd(4'h0, 8'h08);
      rd(4'h7, 8'h01);
      wr(4'h7, 8'h01);
      rd(4'h7, 8'h00);
      // request status
      @(posedge ref_clk);
      ext_request_n <= 2'b10;
      st_n <= 4'b0110;
      repeat (4) @(posedge ref_clk);
      rd(4'h8, 8'h19);
      @(posedge ref_clk);
      ext_request_n <= 2'b11;
      st_n <= 4'hF;
      // pin edge, single, acknowledge source
      clr;
      lat <= 4'h0;
      wr(4'hA, 8'h14);
      wr(4'h3, 8'h07);
      wr(4'h5, 8'h03);
      wr(4'h1, 8'h05);
      pulse(12);
      pulse(12);
      quiet;
      chk(n_wr[15:0], 16'h0002);
      chk(n_ack[15:0], 16'h0002);
      chk(n_rd[15:0], 16'h0000);
      chk(n_oe[15:0], 16'h0000);
      rd(4'h5, 8'h01);
      // pin level, single, memory source
      clr;
      wr(4'h9, 8'h22);
      wr(4'h2, 8'h07);
      wr(4'h4, 8'h03);
      wr(4'h0, 8'h01);
      ext_request_n[0] <= 1'b0;
      quiet;
      ext_request_n[0] <= 1'b1;
      chk(n_rd[15:0], 16'h0003);
      chk(n_ack[15:0], 16'h0003);
      chk(n_irq[15:0], 16'h0001);
      rd(4'h7, 8'h01);
      // peripheral codes, last one maps to nothing
      wr(4'hA, 8'h12);
      for (i = 0; i < 5; i = i + 1) begin
         c = codes[8 * i +: 8];
         wr(4'h3, c);
         wr(4'h5, 8'h01);
         wr(4'h1, 8'h09);
         // pulses stand for peripherals already set up
         @(posedge ref_clk);
         periph_req1 <= (c < 8'h07) ? 24'h1 << (c - 1) : (c < 8'h1A) ? 24'h1 << (c - 2) : 24'hFFFFFF;
         @(posedge ref_clk);
         periph_req1 <= 24'h000000;
         quiet;
         rd(4'h7, (c < 8'h1A) ? 8'h03 : 8'h01);
         wr(4'h7, 8'h02);
      end
      cfg(8'h00, 8'h01, 2'b10);
      cfg(8'h24, 8'h09, 2'b10);
      cfg(8'h12, 8'h09, 2'b00);
      cfg(8'h24, 8'h01, 2'b10);
      cfg(8'h1C, 8'h01, 2'b00);
      give_verdict;
   end
endmodule // dmar_top_test
